// File: hw/pxbar_top.sv
// Priority port crossbar: registers, pin drivers and peripheral routing
// How it works
// - Functions have fixed priority, serial port first, placed in that order.
// - Each enabled function except the serial port takes the lowest free, unskipped candidate pin.
// - Serial transmit and receive always sit on port 0 pins 4 and 5.
// - A pin once given away is never offered to lower functions.
// - Skipped pins count as taken; the search moves on.
// - Skip registers hold one bit per pin, bit n for pin n.
// - Only port 0 pin 0 to port 2 pin 3 carry functions.
// - Reading a port latch returns the synchronised pin state; analog pins read zero.
// - Output mode registers choose push-pull or open-drain per pin, ports 0-3.
// - SPI slave select takes a pin only in four-wire mode.
// - Three 8-bit ports plus one port of 5 or 1 bits.
// - Every pin can be digital I/O or analog input.
// - With crossbar off, all pins stay plain inputs.
// - With crossbar off, every output driver is off.
// - SMBus claims data and clock; serial port claims transmit and receive.
`timescale 1ns/1ps
`include "pxbar_defs.svh"
module pxbar_top #(
   parameter int P3_WIDTH = `PXB_P3_WIDTH,
   parameter int NP       = 24 + P3_WIDTH
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset_n,
   input  wire logic                 clk_en,
   input  wire logic [`PXB_AW-1:0]   reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 spi_four_wire,
   input  wire logic [`PXB_NF-1:0]   fn_out,
   input  wire logic [`PXB_NF-1:0]   fn_drive,
   output logic      [`PXB_NF-1:0]   fn_in,
   input  wire logic [NP-1:0]        pin_in,
   output logic      [NP-1:0]        pin_out,
   output logic      [NP-1:0]        pin_oe_n
);
   // ==========================================================
   // Helpers
   function automatic logic [NP-1:0] flat(input logic [3:0][7:0] r);
      return {r[3][P3_WIDTH-1:0], r[2], r[1], r[0]};
   endfunction

   function automatic logic [7:0] port_byte(input logic [NP-1:0] v, input logic [1:0] n);
      case (n)
         2'h0:    return v[7:0];
         2'h1:    return v[15:8];
         2'h2:    return v[23:16];
         default: return 8'(v[NP-1:24]);
      endcase
   endfunction

   // ==========================================================
   // Registers and internal signals
   logic [7:0]            sel_lo_q;
   logic [7:0]            sel_hi_q;
   logic [3:0][7:0]       skip_q;
   logic [3:0][7:0]       mdout_q;
   logic [3:0][7:0]       mdin_q;
   logic [3:0][7:0]       latch_q;
   logic [7:0]            rdata_q;
   logic [NP-1:0]         pin_out_q;
   logic [NP-1:0]         pin_oe_n_q;
   logic [`PXB_NF-1:0]    fn_in_q;
   logic [NP-1:0]         pin_sync;
   logic [NP-1:0]         pin_state;
   logic [NP-1:0]         mdout_v;
   logic [NP-1:0]         mdin_v;
   logic [NP-1:0]         latch_v;
   logic [NP-1:0]         out_d;
   logic [NP-1:0]         want_v;
   logic [NP-1:0]         od_v;
   logic [NP-1:0]         oe_n_d;
   logic [`PXB_NF-1:0]    req;
   logic [`PXB_NCAND-1:0] skip_v;
   logic                  xbar_en;
   pxbar_pkg::pxbar_func_t fn;

   pxbar_map_if map ();

   assign xbar_en = sel_hi_q[`PXB_SH_XBAR];
   assign mdout_v = flat(mdout_q);
   assign mdin_v  = flat(mdin_q);
   assign latch_v = flat(latch_q);
   assign skip_v  = {skip_q[2][3:0], skip_q[1], skip_q[0]};

   // ==========================================================
   // Register writes, one process per register group
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sel_lo_q <= `PXB_RST_ZERO;
         sel_hi_q <= `PXB_RST_ZERO;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == `PXB_A_SEL_LO) begin
            sel_lo_q <= reg_wdata;
         end
         if (reg_addr == `PXB_A_SEL_HI) begin
            sel_hi_q <= reg_wdata;
         end
      end
   end

   // Skip masks exist for the three ports that hold candidate pins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         skip_q <= '0;
      end else if (clk_en && reg_wr) begin
         for (int k = 0; k < `PXB_NSKIP; k++) begin
            if (reg_addr == `PXB_A_SKIP + `PXB_AW'(k)) begin
               skip_q[k] <= reg_wdata;
            end
         end
      end
   end

   // Output mode, input mode and output latch for all four ports
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mdout_q <= '0;
         mdin_q  <= {`PXB_NPORT{`PXB_RST_MDIN}};
         latch_q <= {`PXB_NPORT{`PXB_RST_LATCH}};
      end else if (clk_en && reg_wr) begin
         for (int k = 0; k < `PXB_NPORT; k++) begin
            if (reg_addr == `PXB_A_MDOUT + `PXB_AW'(k)) begin
               mdout_q[k] <= reg_wdata;
            end
            if (reg_addr == `PXB_A_MDIN + `PXB_AW'(k)) begin
               mdin_q[k] <= reg_wdata;
            end
            if (reg_addr == `PXB_A_LATCH + `PXB_AW'(k)) begin
               latch_q[k] <= reg_wdata;
            end
         end
      end
   end

   // ==========================================================
   // Read data stand for one cycle after the strobe, zero otherwise;
   // the latch address reads the pins, not the written latch
   assign pin_state = pin_sync & mdin_v;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else if (clk_en) begin
         rdata_q <= '0;
         if (reg_rd) begin
            if (reg_addr == `PXB_A_SEL_LO) begin
               rdata_q <= sel_lo_q;
            end
            if (reg_addr == `PXB_A_SEL_HI) begin
               rdata_q <= sel_hi_q;
            end
            for (int k = 0; k < `PXB_NPORT; k++) begin
               if (k < `PXB_NSKIP && reg_addr == `PXB_A_SKIP + `PXB_AW'(k)) begin
                  rdata_q <= skip_q[k];
               end
               if (reg_addr == `PXB_A_MDOUT + `PXB_AW'(k)) begin
                  rdata_q <= mdout_q[k];
               end
               if (reg_addr == `PXB_A_MDIN + `PXB_AW'(k)) begin
                  rdata_q <= mdin_q[k];
               end
               if (reg_addr == `PXB_A_LATCH + `PXB_AW'(k)) begin
                  rdata_q <= port_byte(pin_state, 2'(k));
               end
            end
         end
      end
   end

   assign reg_rdata = rdata_q;

   // ==========================================================
   // Function requests; nothing is requested while the crossbar is off
   always_comb begin
      req = '0;
      req[pxbar_pkg::FN_UART_TX]  = sel_lo_q[`PXB_SL_UART];
      req[pxbar_pkg::FN_UART_RX]  = sel_lo_q[`PXB_SL_UART];
      req[pxbar_pkg::FN_SPI_SCK]  = sel_lo_q[`PXB_SL_SPI];
      req[pxbar_pkg::FN_SPI_MISO] = sel_lo_q[`PXB_SL_SPI];
      req[pxbar_pkg::FN_SPI_MOSI] = sel_lo_q[`PXB_SL_SPI];
      req[pxbar_pkg::FN_SPI_NSS]  = sel_lo_q[`PXB_SL_SPI] && spi_four_wire;
      req[pxbar_pkg::FN_SMB_SDA]  = sel_lo_q[`PXB_SL_SMB];
      req[pxbar_pkg::FN_SMB_SCL]  = sel_lo_q[`PXB_SL_SMB];
      req[pxbar_pkg::FN_SYSCLK]   = sel_lo_q[`PXB_SL_SYSCK];
      req[pxbar_pkg::FN_CP0]      = sel_lo_q[`PXB_SL_CP0];
      req[pxbar_pkg::FN_CP0A]     = sel_lo_q[`PXB_SL_CP0A];
      req[pxbar_pkg::FN_CP1]      = sel_lo_q[`PXB_SL_CP1];
      req[pxbar_pkg::FN_CP1A]     = sel_lo_q[`PXB_SL_CP1A];
      req[pxbar_pkg::FN_T0]       = sel_hi_q[`PXB_SH_T0];
      req[pxbar_pkg::FN_T1]       = sel_hi_q[`PXB_SH_T1];
      if (!xbar_en) begin
         req = '0;
      end
   end

   // The map is pure logic on the registers, so it tracks every write
   pxbar_decoder u_dec (
      .req  (req),
      .skip (skip_v),
      .map  (map.dec)
   );

   pxbar_pin_sync #(.W(NP)) u_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .d       (pin_in),
      .q       (pin_sync)
   );

   // ==========================================================
   // Pin drivers: latch by default, function data on owned pins.
   // Open-drain drives only lows; analog pins never drive.
   always_comb begin
      fn     = pxbar_pkg::FN_UART_TX;
      out_d  = latch_v;
      want_v = '1;
      od_v   = ~mdout_v;
      for (int p = 0; p < `PXB_NCAND; p++) begin
         if (map.pin_valid[p]) begin
            fn        = map.pin_func[p];
            out_d[p]  = fn_out[fn];
            want_v[p] = fn_drive[fn];
            if (fn == pxbar_pkg::FN_SMB_SDA || fn == pxbar_pkg::FN_SMB_SCL) begin
               od_v[p] = 1'b1;
            end
         end
      end
      for (int i = 0; i < NP; i++) begin
         oe_n_d[i] = !(xbar_en && mdin_v[i] && want_v[i] && (!od_v[i] || !out_d[i]));
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pin_out_q  <= '0;
         pin_oe_n_q <= '1;
      end else if (clk_en) begin
         pin_out_q  <= out_d;
         pin_oe_n_q <= oe_n_d;
      end
   end

   assign pin_out  = pin_out_q;
   assign pin_oe_n = pin_oe_n_q;

   // Unplaced functions see an idle high input
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         fn_in_q <= '1;
      end else if (clk_en) begin
         for (int f = 0; f < `PXB_NF; f++) begin
            fn_in_q[f] <= map.fn_placed[f] ? pin_sync[map.fn_pin[f]] : 1'b1;
         end
      end
   end

   assign fn_in = fn_in_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   sequence s_off;
      clk_en && !xbar_en;
   endsequence

   sequence s_sel_clear;
      clk_en && reg_wr && reg_addr == `PXB_A_SEL_LO && reg_wdata == 8'h00;
   endsequence

   sequence s_od_port0;
      clk_en && xbar_en && !mdout_v[0] && !map.pin_valid[0];
   endsequence

   a_uart_fixed_pins: assert property (
      req[pxbar_pkg::FN_UART_TX] |-> map.pin_valid[`PXB_TX_PIN]
         && map.pin_func[`PXB_TX_PIN] == pxbar_pkg::FN_UART_TX
         && map.pin_func[`PXB_RX_PIN] == pxbar_pkg::FN_UART_RX)
      else $error("serial pins not on fixed pins");

   a_skip_excludes: assert property (
      (!req[pxbar_pkg::FN_UART_TX] && skip_v[0]) |-> !map.pin_valid[0])
      else $error("skipped pin was assigned");

   a_pin_unique: assert property (
      (map.fn_placed[pxbar_pkg::FN_SPI_SCK] && map.fn_placed[pxbar_pkg::FN_SPI_MISO])
      |-> map.fn_pin[pxbar_pkg::FN_SPI_SCK] != map.fn_pin[pxbar_pkg::FN_SPI_MISO])
      else $error("two functions share a pin");

   a_priority_order: assert property (
      (map.fn_placed[pxbar_pkg::FN_SMB_SDA] && map.fn_placed[pxbar_pkg::FN_SYSCLK])
      |-> map.fn_pin[pxbar_pkg::FN_SMB_SDA] < map.fn_pin[pxbar_pkg::FN_SYSCLK])
      else $error("lower priority placed first");

   a_lowest_first: assert property (
      (req[pxbar_pkg::FN_SPI_SCK] && !req[pxbar_pkg::FN_UART_TX] && skip_v == '0)
      |-> map.fn_pin[pxbar_pkg::FN_SPI_SCK] == `PXB_FW'(0))
      else $error("first function not on pin 0");

   a_nss_three_wire: assert property (
      !spi_four_wire |-> !map.fn_placed[pxbar_pkg::FN_SPI_NSS])
      else $error("slave select placed in three-wire mode");

   a_off_no_drive: assert property (
      s_off |=> (pin_oe_n == '1) && (fn_in == '1))
      else $error("pin driven with crossbar off");

   a_latch_read: assert property (
      (clk_en && reg_rd && reg_addr == `PXB_A_LATCH) |=> reg_rdata == $past(pin_state[7:0]))
      else $error("port read is not pin state");

   a_open_drain_high: assert property (
      s_od_port0 |=> !(pin_out[0] && !pin_oe_n[0]))
      else $error("open-drain pin drove a high");

   a_map_follows: assert property (
      s_sel_clear |=> !map.fn_placed[pxbar_pkg::FN_UART_TX] && !map.fn_placed[pxbar_pkg::FN_SPI_SCK])
      else $error("map did not follow select write");
endmodule

// File: hw/pxbar_defs.svh
// Register offsets, field positions, reset values and sizes of the port crossbar
`ifndef PXBAR_DEFS_SVH
`define PXBAR_DEFS_SVH

// ==========================================================
// Register map (word index on the plain register port)
`define PXB_AW          5
`define PXB_A_SEL_LO    5'h00
`define PXB_A_SEL_HI    5'h01
`define PXB_A_SKIP      5'h02
`define PXB_A_MDOUT     5'h05
`define PXB_A_MDIN      5'h09
`define PXB_A_LATCH     5'h0D
`define PXB_NSKIP       3
`define PXB_NPORT       4

// ==========================================================
// Fields of peripheral_select_low
`define PXB_SL_UART     0
`define PXB_SL_SPI      1
`define PXB_SL_SMB      2
`define PXB_SL_SYSCK    3
`define PXB_SL_CP0      4
`define PXB_SL_CP0A     5
`define PXB_SL_CP1      6
`define PXB_SL_CP1A     7
// Fields of peripheral_select_high
`define PXB_SH_T0       0
`define PXB_SH_T1       1
`define PXB_SH_XBAR     6

// ==========================================================
// Reset values
`define PXB_RST_ZERO    8'h00
`define PXB_RST_MDIN    8'hFF
`define PXB_RST_LATCH   8'hFF

// ==========================================================
// Sizes and fixed pins
`define PXB_NCAND       20
`define PXB_NF          15
`define PXB_FW          5
`define PXB_TX_PIN      4
`define PXB_RX_PIN      5
`define PXB_P3_WIDTH    5

`endif

// File: hw/pxbar_pkg.sv
// Types shared by the port crossbar modules
package pxbar_pkg;

   // ==========================================================
   // Crossbar functions, listed in falling priority
   typedef enum logic [3:0] {
      FN_UART_TX,
      FN_UART_RX,
      FN_SPI_SCK,
      FN_SPI_MISO,
      FN_SPI_MOSI,
      FN_SPI_NSS,
      FN_SMB_SDA,
      FN_SMB_SCL,
      FN_SYSCLK,
      FN_CP0,
      FN_CP0A,
      FN_CP1,
      FN_CP1A,
      FN_T0,
      FN_T1
   } pxbar_func_t;

endpackage

// File: hw/pxbar_map_if.sv
// Pin assignment map passed from the priority decoder to the top
`timescale 1ns/1ps
`include "pxbar_defs.svh"
interface pxbar_map_if;
   logic                  pin_valid [`PXB_NCAND];
   pxbar_pkg::pxbar_func_t pin_func [`PXB_NCAND];
   logic [`PXB_NF-1:0]    fn_placed;
   logic [`PXB_FW-1:0]    fn_pin [`PXB_NF];

   modport dec (output pin_valid, output pin_func, output fn_placed, output fn_pin);
   modport top (input pin_valid, input pin_func, input fn_placed, input fn_pin);
endinterface

// File: hw/pxbar_pin_sync.sv
// Two-stage synchroniser for the port pin inputs
`timescale 1ns/1ps
module pxbar_pin_sync #(
   parameter int W = 29
) (
   input  wire logic         sys_clk,
   input  wire logic         reset_n,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ==========================================================
   // Only the second stage is visible to any logic
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clk_en) begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule

// File: hw/pxbar_decoder.sv
// Priority decoder: places each requested function on the lowest free pin, serial port on its fixed pins
`timescale 1ns/1ps
`include "pxbar_defs.svh"
module pxbar_decoder (
   input  wire logic [`PXB_NF-1:0]    req,
   input  wire logic [`PXB_NCAND-1:0] skip,
   pxbar_map_if.dec                   map
);
   // Lowest pin not yet taken, with a found flag on top
   function automatic logic [`PXB_FW:0] lowest_free(input logic [`PXB_NCAND-1:0] t);
      logic [`PXB_FW:0] r;
      r = '0;
      for (int i = `PXB_NCAND - 1; i >= 0; i--) begin
         if (!t[i]) begin
            r = {1'b1, `PXB_FW'(i)};
         end
      end
      return r;
   endfunction

   logic [`PXB_NCAND-1:0] taken;
   logic [`PXB_FW:0]      slot;
   logic [`PXB_FW-1:0]    p;

   // ==========================================================
   // Walk the functions from highest priority down; the search space
   // is only the candidate pins, later pins are never offered
   always_comb begin
      taken = skip;
      slot  = '0;
      p     = '0;
      map.fn_placed = '0;
      for (int i = 0; i < `PXB_NCAND; i++) begin
         map.pin_valid[i] = 1'b0;
         map.pin_func[i]  = pxbar_pkg::FN_UART_TX;
      end
      for (int f = 0; f < `PXB_NF; f++) begin
         map.fn_pin[f] = '0;
      end
      for (int f = 0; f < `PXB_NF; f++) begin
         if (req[f]) begin
            if (f == int'(pxbar_pkg::FN_UART_TX)) begin
               slot = {1'b1, `PXB_FW'(`PXB_TX_PIN)};
            end else if (f == int'(pxbar_pkg::FN_UART_RX)) begin
               slot = {1'b1, `PXB_FW'(`PXB_RX_PIN)};
            end else begin
               slot = lowest_free(taken);
            end
            if (slot[`PXB_FW]) begin
               p = slot[`PXB_FW-1:0];
               taken[p]          = 1'b1;
               map.pin_valid[p]  = 1'b1;
               map.pin_func[p]   = pxbar_pkg::pxbar_func_t'(f);
               map.fn_placed[f]  = 1'b1;
               map.fn_pin[f]     = p;
            end
         end
      end
   end
endmodule

// File: test/pxbar_pad_model.sv
// Board model around the port pins: pull-ups and external drivers
`timescale 1ns/1ps
module pxbar_pad_model #(
   parameter int NP = 29
) (
   input  wire logic [NP-1:0] pin_out,
   input  wire logic [NP-1:0] pin_oe_n,
   input  wire logic [NP-1:0] ext_val,
   output logic      [NP-1:0] pin_level
);
   // ==========
   // Pad resolution
   // A released pad shows the board driver (pulled high by default), never the last driven value
   always_comb begin
      pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
   end
endmodule

// File: test/priority_port_crossbar_bench.sv
// Self-checking bench for the priority port crossbar
`timescale 1ns/1ps
`include "pxbar_defs.svh"
module priority_port_crossbar_bench;
   logic               sys_clk;
   logic               reset_n;
   logic               clk_en;
   logic [`PXB_AW-1:0] reg_addr;
   logic [7:0]         reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [7:0]         reg_rdata;
   logic               spi_four_wire;
   logic [`PXB_NF-1:0] fn_out;
   logic [`PXB_NF-1:0] fn_drive;
   logic [`PXB_NF-1:0] fn_in;
   logic [28:0]        pin_in;
   logic [28:0]        pin_out;
   logic [28:0]        pin_oe_n;
   logic [28:0]        ext_val;
   logic [7:0]         rd_val;
   int                 errors;
   int                 cmp_count;

   pxbar_top #(.P3_WIDTH(5)) dut (
      .sys_clk       (sys_clk),
      .reset_n       (reset_n),
      .clk_en        (clk_en),
      .reg_addr      (reg_addr),
      .reg_wdata     (reg_wdata),
      .reg_wr        (reg_wr),
      .reg_rd        (reg_rd),
      .reg_rdata     (reg_rdata),
      .spi_four_wire (spi_four_wire),
      .fn_out        (fn_out),
      .fn_drive      (fn_drive),
      .fn_in         (fn_in),
      .pin_in        (pin_in),
      .pin_out       (pin_out),
      .pin_oe_n      (pin_oe_n)
   );

   pxbar_pad_model #(.NP(29)) pads (
      .pin_out   (pin_out),
      .pin_oe_n  (pin_oe_n),
      .ext_val   (ext_val),
      .pin_level (pin_in)
   );

   // ==========
   // Clock, 25 ns period
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ==========
   // Bus and compare helpers
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just after that edge
   task automatic rd(input logic [4:0] a);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========
   // Scenarios
   task automatic t_reset();
      logic [4:0] a [6];
      logic [7:0] e [6];
      a = '{`PXB_A_SEL_LO, `PXB_A_SEL_HI, `PXB_A_SKIP, `PXB_A_MDOUT, `PXB_A_MDIN, 5'h1F};
      e = '{8'h00, 8'h00, 8'h00, 8'h00, `PXB_RST_MDIN, 8'h00};
      chk_bit("all drivers off", 1'b1, &pin_oe_n);
      chk_bit("unplaced input", 1'b1, fn_in[pxbar_pkg::FN_T1]);
      chk_byte("pin count", 8'h1D, 8'($bits(pin_out)));
      for (int i = 0; i < 6; i++) begin
         rd(a[i]);
         chk_byte("reset value", e[i], rd_val);
      end
      wr(5'h1F, 8'h5A);
      rd(5'h1F);
      chk_byte("unmapped read", 8'h00, rd_val);
      $display("test reset done");
   endtask

   // Crossbar off: every peripheral_select_low function selected, yet nothing drives and the latch still reads the pads
   task automatic t_off();
      @(posedge sys_clk);
      ext_val <= {21'h1FFFFF, 8'hA5};
      wr(`PXB_A_MDOUT, 8'hFF);
      wr(`PXB_A_LATCH, 8'h00);
      wr(`PXB_A_SEL_LO, 8'hFF);
      settle(3);
      chk_bit("drivers off", 1'b1, &pin_oe_n);
      rd(`PXB_A_LATCH);
      chk_byte("latch off", 8'hA5, rd_val);
      $display("test off done");
   endtask

   task automatic t_spi();
      wr(`PXB_A_SEL_LO, 8'h00);
      wr(`PXB_A_SEL_HI, 8'h40);
      wr(`PXB_A_LATCH, 8'hFF);
      @(posedge sys_clk);
      fn_drive      <= ~((15'h1 << pxbar_pkg::FN_SPI_MISO) | (15'h1 << pxbar_pkg::FN_UART_RX));
      fn_out        <= 15'h1 << pxbar_pkg::FN_SMB_SDA;
      ext_val       <= ~29'h2;
      spi_four_wire <= 1'b0;
      wr(`PXB_A_SEL_LO, 8'h02);
      settle(1);
      chk_byte("spi3 drive", 8'hF8, pin_out[7:0] & ~pin_oe_n[7:0]);
      chk_byte("spi3 oe_n", 8'h02, pin_oe_n[7:0]);
      settle(4);
      chk_bit("miso in", 1'b0, fn_in[pxbar_pkg::FN_SPI_MISO]);
      @(posedge sys_clk);
      spi_four_wire <= 1'b1;
      settle(2);
      chk_byte("spi4 drive", 8'hF0, pin_out[7:0] & ~pin_oe_n[7:0]);
      wr(`PXB_A_SEL_LO, 8'h07);
      settle(1);
      chk_byte("uart smb oe_n", 8'h62, pin_oe_n[7:0]);
      chk_byte("uart smb drive", 8'h00, pin_out[7:0] & ~pin_oe_n[7:0]);
      chk_byte("port1 free", 8'hFF, pin_oe_n[15:8]);
      settle(3);
      rd(`PXB_A_LATCH);
      chk_byte("latch owned", 8'h60, rd_val);
      $display("test spi done");
   endtask

   // Oscillator pins 2 and 3 skipped, as software does for pins used outside the crossbar
   task automatic t_skip();
      wr(`PXB_A_MDOUT + 5'h01, 8'hFF);
      wr(`PXB_A_SKIP, 8'h0C);
      settle(1);
      chk_byte("skip p0 oe_n", 8'h22, pin_oe_n[7:0]);
      chk_byte("skip p0 drive", 8'h0C, pin_out[7:0] & ~pin_oe_n[7:0]);
      chk_byte("skip p1 oe_n", 8'h01, pin_oe_n[15:8]);
      chk_byte("skip p1 drive", 8'hFC, pin_out[15:8] & ~pin_oe_n[15:8]);
      $display("test skip done");
   endtask

   task automatic t_range();
      logic [7:0] lo;
      logic [7:0] hi;
      wr(`PXB_A_SKIP, 8'h00);
      wr(`PXB_A_SEL_LO, 8'h00);
      @(posedge sys_clk);
      fn_out   <= '0;
      fn_drive <= '1;
      settle(1);
      chk_bit("pin0 gpio", 1'b1, pin_out[0]);
      for (int k = 0; k < 9; k++) begin
         lo = (k < 7) ? (8'h02 << k) : 8'h00;
         hi = (k < 7) ? 8'h40 : (8'h40 | (8'h01 << (k - 7)));
         wr(`PXB_A_SEL_LO, lo);
         wr(`PXB_A_SEL_HI, hi);
         settle(1);
         chk_bit("pin0 function", 1'b0, pin_out[0]);
      end
      wr(`PXB_A_SKIP, 8'hFF);
      wr(`PXB_A_SKIP + 5'h01, 8'hFF);
      wr(`PXB_A_MDOUT + 5'h02, 8'hFF);
      wr(`PXB_A_LATCH + 5'h02, 8'h00);
      wr(`PXB_A_SEL_LO, 8'hFC);
      wr(`PXB_A_SEL_HI, 8'h43);
      @(posedge sys_clk);
      fn_out <= '1;
      settle(5);
      chk_byte("port2 oe_n", 8'h03, pin_oe_n[23:16]);
      chk_byte("port2 drive", 8'h0F, pin_out[23:16]);
      chk_bit("no pin left", 1'b1, fn_in[pxbar_pkg::FN_T1]);
      $display("test range done");
   endtask

   task automatic t_mode();
      wr(`PXB_A_SEL_LO, 8'h00);
      wr(`PXB_A_SEL_HI, 8'h40);
      wr(`PXB_A_SKIP, 8'h00);
      wr(`PXB_A_MDOUT, 8'h00);
      wr(`PXB_A_LATCH, 8'h0F);
      settle(1);
      chk_byte("open drain oe_n", 8'h0F, pin_oe_n[7:0]);
      chk_byte("open drain drive", 8'h00, pin_out[7:0] & ~pin_oe_n[7:0]);
      wr(`PXB_A_MDOUT, 8'hFF);
      wr(`PXB_A_SKIP, 8'h01);
      wr(`PXB_A_MDIN, 8'hFE);
      settle(3);
      chk_byte("analog oe_n", 8'h01, pin_oe_n[7:0]);
      rd(`PXB_A_LATCH);
      chk_byte("analog latch", 8'h0E, rd_val);
      // A frozen clock enable must swallow the write
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(`PXB_A_MDOUT, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rd(`PXB_A_MDOUT);
      chk_byte("frozen write", 8'hFF, rd_val);
      $display("test mode done");
   endtask

   // ==========
   // Watchdog: a hang counts as a mismatch and ends the run
   initial begin
      for (int i = 0; i < 20000; i++) begin
         @(posedge sys_clk);
      end
      errors++;
      $display("mismatch watchdog expected finish seen hang");
      final_report();
   end

   // ==========
   // Main sequence
   initial begin
      reset_n       = 1'b0;
      clk_en        = 1'b1;
      reg_addr      = '0;
      reg_wdata     = 8'h00;
      reg_wr        = 1'b0;
      reg_rd        = 1'b0;
      spi_four_wire = 1'b0;
      fn_out        = '0;
      fn_drive      = '0;
      ext_val       = '1;
      errors        = 0;
      cmp_count     = 0;
      repeat (3) @(posedge sys_clk);
      #1;
      chk_byte("rdata in reset", 8'h00, reg_rdata);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      settle(1);
      t_reset();
      t_off();
      t_spi();
      t_skip();
      t_range();
      t_mode();
      final_report();
   end
endmodule
